// file: rtl/run_limit_defs.svh
// constants for the run-until-limit command path
`ifndef RUN_LIMIT_DEFS_SVH
`define RUN_LIMIT_DEFS_SVH
// core clock rate in hertz
`define CLK_HZ          27'd100000000
// clock cycles in one percent of a second
`define CLK_PER_PCT     27'd1000000
// accepted pulse rate in hertz
`define FREQ_MIN        16'd20
`define FREQ_MAX        16'd20000
// duty percent that means half on, half off
`define DUTY_HALF       7'd50
// command codes on the command port
`define CMD_READ_ERR    8'h01
`define CMD_RUN_LIMIT   8'h02
// limit selector fields
`define LIM_IN_LSB      0
`define LIM_EDGE_LSB    4
`define LIM_IN_MAX      4'h3
`define LIM_EDGE_MAX    4'h2
// edge kinds
`define EDGE_RISE       4'h0
`define EDGE_FALL       4'h1
// error codes, decimal values
`define ERR_NONE        16'd0
`define ERR_BAD_CMD     16'd100
`define ERR_NO_FILE     16'd101
`define ERR_FILE_TYPE   16'd102
`define ERR_PROFILE     16'd103
`define ERR_NOT_LIMIT   16'd104
`define ERR_EDGE_RANGE  16'd105
`define ERR_IN_FUNC     16'd106
`define ERR_IN_FUNC_NUM 16'd107
`define ERR_PRESET_FN   16'd108
`define ERR_TABLE_FULL  16'd109
`define ERR_TABLE_IDX   16'd110
`define ERR_REG_NUM     16'd111
`define ERR_REG_UNCFG   16'd112
`define ERR_REMOTE      16'd2001
`endif

// file: rtl/run_limit_pkg.sv
// types shared by both ends of the command path
package run_limit_pkg;
    typedef logic [15:0] err_code_t;
    typedef logic [7:0]  cmd_code_t;
    typedef enum logic [1:0] {
        D_IDLE  = 2'b01,
        D_CHECK = 2'b10
    } dev_state_t;
    typedef enum logic [6:0] {
        H_IDLE  = 7'b0000001,
        H_ISSUE = 7'b0000010,
        H_WAIT  = 7'b0000100,
        H_DIR   = 7'b0001000,
        H_ENA   = 7'b0010000,
        H_RDISS = 7'b0100000,
        H_RDWT  = 7'b1000000
    } host_state_t;
endpackage

// file: rtl/run_limit_if.sv
// command port between host controller and pulse module
`timescale 1ns/1ps
interface run_limit_if;
    import run_limit_pkg::*;
    logic      cmdReq;
    cmd_code_t cmdCode;
    logic [7:0]  moduleNumber;
    logic [1:0]  outSel;
    logic [15:0] freqHz;
    logic [7:0]  limitSel;
    logic [7:0]  dutyCode;
    logic        doneOk;
    logic        doneErr;
    err_code_t   errCode;
    logic        errCodeValid;
    logic [3:0]  dirCtl;
    logic [3:0]  outEnable;
    modport dev (input cmdReq, cmdCode, moduleNumber, outSel, freqHz, limitSel, dutyCode,
                 dirCtl, outEnable, output doneOk, doneErr, errCode, errCodeValid);
    modport host (output cmdReq, cmdCode, moduleNumber, outSel, freqHz, limitSel, dutyCode,
                  dirCtl, outEnable, input doneOk, doneErr, errCode, errCodeValid);
endinterface

// file: rtl/run_limit_dev.sv
// pulse module end: command decode, error store, pulse trains
// Operation
// - read-error rising edge returns stored code
// - code kept until next command other than a read
// - remote link access returns code 2001
// - code 0 none, 100 unknown command
// - codes 101 to 103 for file errors
// - 104 not a limit, 105 bad edge
// - 106 bad input function, 107 range
// - 108 preset, 109 full, 110 index
// - 111 register range, 112 unconfigured register
// - run rising edge loads channel parameters
// - host configures limit inputs beforehand
// - low digit input, high digit edge
// - pulse rate 20 to 20000 hertz
// - duty two-digit BCD percent, 0 and 50 halve
// - host addresses module and one of four outputs
// - exactly one of success or error
// - pulse until limit event, then stop
// - host sets direction then enables output
// - host keeps workspace private
`timescale 1ns/1ps
`include "run_limit_defs.svh"
module run_limit_dev
(
    run_limit_if.dev       cmd,
    input  wire logic      core_clk,
    input  wire logic      rst_b,
    input  wire logic [7:0] myNumber,
    input  wire logic      remoteLinked,
    input  wire logic [3:0] limitCfg,
    input  wire logic [3:0] limitPin,
    output logic [3:0]     pulseOut,
    output logic [3:0]     dirOut,
    output logic [3:0]     running
);
    import run_limit_pkg::*;

    // ****************************************
    // functions
    // ****************************************
    // duty code to percent, zero meaning half
    function automatic logic [6:0] dutyPct(input logic [7:0] d);
        logic [6:0] p;
        p = 7'(d[7:4]) * 7'd10 + {3'h0, d[3:0]};
        dutyPct = (p == 7'd0) ? `DUTY_HALF : p;
    endfunction

    // edge selector match
    function automatic logic edgeHit(input logic [3:0] e, input logic r, input logic f);
        case (e)
            `EDGE_RISE: edgeHit = r;
            `EDGE_FALL: edgeHit = f;
            default:    edgeHit = r | f;
        endcase
    endfunction

    // ****************************************
    // command capture
    // ****************************************
    dev_state_t  state;
    logic        reqPrev;
    cmd_code_t   code;
    logic [1:0]  ch;
    logic [15:0] freq;
    logic [7:0]  lim;
    logic [7:0]  duty;
    err_code_t   errStore;
    err_code_t   next_err;
    logic        reqRise;

    assign reqRise = cmd.cmdReq & ~reqPrev & (cmd.moduleNumber == myNumber);

    // request edge detector
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            reqPrev <= 1'b0;
        else
            reqPrev <= cmd.cmdReq;
    end

    // latch parameters on a new command
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            code <= 8'h00;
            ch   <= 2'h0;
            freq <= 16'h0000;
            lim  <= 8'h00;
            duty <= 8'h00;
        end
        else if (reqRise && state == D_IDLE)
        begin
            code <= cmd.cmdCode;
            ch   <= cmd.outSel;
            freq <= cmd.freqHz;
            lim  <= cmd.limitSel;
            duty <= cmd.dutyCode;
        end
    end

    // ****************************************
    // validation
    // ****************************************
    // error decided for the latched command
    always_comb
    begin
        next_err = `ERR_NONE;
        if (code != `CMD_RUN_LIMIT)
            next_err = `ERR_BAD_CMD;
        else if (lim[`LIM_IN_LSB +: 4] > `LIM_IN_MAX)
            next_err = `ERR_NOT_LIMIT;
        else if (lim[`LIM_EDGE_LSB +: 4] > `LIM_EDGE_MAX)
            next_err = `ERR_EDGE_RANGE;
        else if (!limitCfg[lim[1:0]])
            next_err = `ERR_NOT_LIMIT;
        else if (freq < `FREQ_MIN || freq > `FREQ_MAX)
            next_err = `ERR_BAD_CMD;
        else if (duty[7:4] > 4'h9 || duty[3:0] > 4'h9)
            next_err = `ERR_BAD_CMD;
    end

    // ****************************************
    // sequencing and answer
    // ****************************************
    // two-step execution
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= D_IDLE;
        else
        begin
            case (state)
                D_IDLE:  if (reqRise) state <= D_CHECK;
                D_CHECK: state <= D_IDLE;
                default: state <= D_IDLE;
            endcase
        end
    end

    // completion flags, one of two per command
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd.doneOk  <= 1'b0;
            cmd.doneErr <= 1'b0;
        end
        else if (reqRise && state == D_IDLE)
        begin
            cmd.doneOk  <= 1'b0;
            cmd.doneErr <= 1'b0;
        end
        else if (state == D_CHECK)
        begin
            if (code == `CMD_READ_ERR)
            begin
                cmd.doneOk  <= ~remoteLinked;
                cmd.doneErr <= remoteLinked;
            end
            else
            begin
                cmd.doneOk  <= (next_err == `ERR_NONE);
                cmd.doneErr <= (next_err != `ERR_NONE);
            end
        end
    end

    // stored error code for the last command other than a read
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            errStore <= `ERR_NONE;
        else if (state == D_CHECK && code != `CMD_READ_ERR)
            errStore <= next_err;
    end

    // error code read back
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd.errCode      <= `ERR_NONE;
            cmd.errCodeValid <= 1'b0;
        end
        else
        begin
            cmd.errCodeValid <= 1'b0;
            if (state == D_CHECK && code == `CMD_READ_ERR)
            begin
                cmd.errCode      <= remoteLinked ? `ERR_REMOTE : errStore;
                cmd.errCodeValid <= 1'b1;
            end
        end
    end

    // ****************************************
    // limit inputs
    // ****************************************
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic [3:0] filtPrev;

    // three-stage synchroniser, level taken on agreement
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1       <= 4'h0;
            s2       <= 4'h0;
            s3       <= 4'h0;
            filt     <= 4'h0;
            filtPrev <= 4'h0;
        end
        else
        begin
            s1       <= limitPin;
            s2       <= s1;
            s3       <= s2;
            filt     <= (s2 & s3) | (filt & (s2 ^ s3));
            filtPrev <= filt;
        end
    end

    // ****************************************
    // output channels
    // ****************************************
    logic [15:0] chFreq [4];
    logic [26:0] chHigh [4];
    logic [1:0]  chIn   [4];
    logic [3:0]  chEdge [4];
    logic        loadNow;

    assign loadNow = (state == D_CHECK) && (next_err == `ERR_NONE);

    // per-channel parameter store
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 4; i++)
            begin
                chFreq[i] <= 16'h0000;
                chHigh[i] <= 27'h0000000;
                chIn[i]   <= 2'h0;
                chEdge[i] <= 4'h0;
            end
        end
        else if (loadNow)
        begin
            chFreq[ch] <= freq;
            chHigh[ch] <= 27'(dutyPct(duty) * `CLK_PER_PCT);
            chIn[ch]   <= lim[1:0];
            chEdge[ch] <= lim[`LIM_EDGE_LSB +: 4];
        end
    end

    // direction follows host control
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            dirOut <= 4'h0;
        else
            dirOut <= cmd.dirCtl;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_ch
            logic [26:0] acc;
            logic [26:0] sum;
            logic        hit;

            assign sum = acc + {11'h000, chFreq[g]};
            assign hit = edgeHit(chEdge[g], filt[chIn[g]] & ~filtPrev[chIn[g]],
                                 ~filt[chIn[g]] & filtPrev[chIn[g]]);

            // armed until the chosen limit event
            always_ff @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    running[g] <= 1'b0;
                else if (loadNow && ch == g)
                    running[g] <= 1'b1;
                else if (hit)
                    running[g] <= 1'b0;
            end

            // phase accumulator pulse train
            always_ff @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    acc         <= 27'h0000000;
                    pulseOut[g] <= 1'b0;
                end
                else if (running[g] && cmd.outEnable[g] && !hit)
                begin
                    acc         <= (sum >= `CLK_HZ) ? sum - `CLK_HZ : sum;
                    pulseOut[g] <= (acc < chHigh[g]);
                end
                else
                begin
                    acc         <= 27'h0000000;
                    pulseOut[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// file: rtl/run_limit_host.sv
// host controller end: issues commands and follows them up
`timescale 1ns/1ps
`include "run_limit_defs.svh"
module run_limit_host
(
    run_limit_if.host      cmd,
    input  wire logic      core_clk,
    input  wire logic      rst_b,
    input  wire logic      startRun,
    input  wire logic      startReadErr,
    input  wire logic [7:0] userModule,
    input  wire logic [1:0] userOut,
    input  wire logic [15:0] userFreq,
    input  wire logic [7:0] userLimit,
    input  wire logic [7:0] userDuty,
    input  wire logic      userDir,
    input  wire logic [3:0] userDisable,
    output logic           busy,
    output logic           runOk,
    output logic           runErr,
    output run_limit_pkg::err_code_t lastErrCode
);
    import run_limit_pkg::*;

    // ****************************************
    // sequencer
    // ****************************************
    host_state_t state;
    logic        isRun;
    logic        holdOff; // old flags still stand for one cycle

    // command, follow-up and error read
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state             <= H_IDLE;
            isRun             <= 1'b0;
            holdOff           <= 1'b0;
            cmd.cmdReq        <= 1'b0;
            cmd.cmdCode       <= 8'h00;
            cmd.moduleNumber  <= 8'h00;
            cmd.outSel        <= 2'h0;
            cmd.freqHz        <= 16'h0000;
            cmd.limitSel      <= 8'h00;
            cmd.dutyCode      <= 8'h00;
        end
        else
        begin
            holdOff <= 1'b0;
            case (state)
                H_IDLE:
                    if (startRun || startReadErr)
                    begin
                        isRun            <= startRun;
                        cmd.cmdCode      <= startRun ? `CMD_RUN_LIMIT : `CMD_READ_ERR;
                        cmd.moduleNumber <= userModule;
                        cmd.outSel       <= userOut;
                        cmd.freqHz       <= userFreq;
                        cmd.limitSel     <= userLimit;
                        cmd.dutyCode     <= userDuty;
                        state            <= H_ISSUE;
                    end
                H_ISSUE:
                begin
                    cmd.cmdReq <= 1'b1;
                    holdOff    <= 1'b1;
                    state      <= H_WAIT;
                end
                H_WAIT:
                    if (!holdOff && (cmd.doneOk || cmd.doneErr))
                    begin
                        cmd.cmdReq <= 1'b0;
                        if (isRun && cmd.doneOk)
                            state <= H_DIR;
                        else if (isRun)
                            state <= H_RDISS;
                        else
                            state <= H_IDLE;
                    end
                H_DIR:   state <= H_ENA;
                H_ENA:   state <= H_IDLE;
                H_RDISS:
                begin
                    cmd.cmdCode <= `CMD_READ_ERR;
                    cmd.cmdReq  <= 1'b1;
                    holdOff     <= 1'b1;
                    state       <= H_RDWT;
                end
                H_RDWT:
                    if (!holdOff && (cmd.doneOk || cmd.doneErr))
                    begin
                        cmd.cmdReq <= 1'b0;
                        state      <= H_IDLE;
                    end
                default: state <= H_IDLE;
            endcase
        end
    end

    // direction first, then enable
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd.dirCtl    <= 4'h0;
            cmd.outEnable <= 4'h0;
        end
        else
        begin
            if (state == H_DIR)
                cmd.dirCtl[cmd.outSel] <= userDir;
            if (state == H_ENA)
                cmd.outEnable <= (cmd.outEnable | (4'h1 << cmd.outSel)) & ~userDisable;
            else
                cmd.outEnable <= cmd.outEnable & ~userDisable;
        end
    end

    // user status
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy        <= 1'b0;
            runOk       <= 1'b0;
            runErr      <= 1'b0;
            lastErrCode <= `ERR_NONE;
        end
        else
        begin
            busy <= (state != H_IDLE) || startRun || startReadErr;
            if (state == H_WAIT && !holdOff && (cmd.doneOk || cmd.doneErr) && isRun)
            begin
                runOk  <= cmd.doneOk;
                runErr <= cmd.doneErr;
            end
            if (cmd.errCodeValid)
                lastErrCode <= cmd.errCode;
        end
    end
endmodule

// file: dv/run_limit_checker.sv
// concurrent checks on the command port between host and module
`timescale 1ns/1ps
`include "run_limit_defs.svh"
module run_limit_checker
(
    input wire logic                     core_clk,
    input wire logic                     rst_b,
    input wire logic                     cmdReq,
    input wire run_limit_pkg::cmd_code_t cmdCode,
    input wire logic [15:0]              freqHz,
    input wire logic [7:0]               limitSel,
    input wire logic [7:0]               dutyCode,
    input wire logic                     doneOk,
    input wire logic                     doneErr,
    input wire run_limit_pkg::err_code_t errCode,
    input wire logic                     errCodeValid
);
    import run_limit_pkg::*;
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // a run request as seen on the port
    sequence s_run;
        $rose(cmdReq) && cmdCode == `CMD_RUN_LIMIT;
    endsequence

    property p_answer;
        $rose(cmdReq) |-> ##2 (doneOk || doneErr);
    endproperty
    property p_clear;
        $rose(cmdReq) |=> !doneOk && !doneErr;
    endproperty
    property p_oneFlag;
        !(doneOk && doneErr);
    endproperty
    property p_flagsStand;
        (doneOk || doneErr) && !cmdReq |=> $stable(doneOk) && $stable(doneErr);
    endproperty
    property p_readValid;
        $rose(cmdReq) && cmdCode == `CMD_READ_ERR |-> ##2 errCodeValid;
    endproperty
    property p_validOnce;
        errCodeValid |=> !errCodeValid;
    endproperty
    property p_codeHold;
        $changed(errCode) |-> errCodeValid;
    endproperty
    property p_edgeRange;
        s_run ##0 limitSel[7:4] > `LIM_EDGE_MAX |-> ##2 doneErr;
    endproperty
    property p_inRange;
        s_run ##0 limitSel[3:0] > `LIM_IN_MAX |-> ##2 doneErr;
    endproperty
    property p_freqRange;
        s_run ##0 (freqHz < `FREQ_MIN || freqHz > `FREQ_MAX) |-> ##2 doneErr;
    endproperty
    property p_dutyCode;
        s_run ##0 (dutyCode[3:0] > 4'h9 || dutyCode[7:4] > 4'h9) |-> ##2 doneErr;
    endproperty

    // ****************************************
    // assertions and covers
    // ****************************************
    a_answer: assert property (p_answer)
        else $error("no completion flag two cycles after request");
    a_clear: assert property (p_clear)
        else $error("flags not cleared when request taken");
    a_oneFlag: assert property (p_oneFlag)
        else $error("success and error flags both set");
    a_flagsStand: assert property (p_flagsStand)
        else $error("completion flag changed without request");
    a_readValid: assert property (p_readValid)
        else $error("read request gave no code");
    a_validOnce: assert property (p_validOnce)
        else $error("code valid longer than one cycle");
    a_codeHold: assert property (p_codeHold)
        else $error("error code changed without valid");
    a_edgeRange: assert property (p_edgeRange)
        else $error("bad edge selector accepted");
    a_inRange: assert property (p_inRange)
        else $error("bad input selector accepted");
    a_freqRange: assert property (p_freqRange)
        else $error("pulse rate out of range accepted");
    a_dutyCode: assert property (p_dutyCode)
        else $error("non decimal duty accepted");
    c_ok: cover property ($rose(doneOk));
    c_err: cover property ($rose(doneErr));
    c_remote: cover property (errCodeValid && errCode == `ERR_REMOTE);
endmodule

// file: dv/pulse_run_to_limit_cmd_tb.sv
// self-checking bench for host and module joined on the command port
`timescale 1ns/1ps
`include "run_limit_defs.svh"
`define CHK(what, exp, got) \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
        n_mismatch++; \
        $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
    end
module pulse_run_to_limit_cmd_tb;
    import run_limit_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        startRun = 1'b0;
    logic        startReadErr = 1'b0;
    logic [1:0]  userOut = 2'h0;
    logic [15:0] userFreq = 16'd20000;
    logic [7:0]  userLimit = 8'h00;
    logic [7:0]  userDuty = 8'h00;
    logic        userDir = 1'b1;
    logic [3:0]  userDisable = 4'h0;
    logic        remoteLinked = 1'b0;
    logic [3:0]  limitCfg = 4'hf;
    logic [3:0]  limitPin = 4'h0;
    logic [3:0]  pulseOut, dirOut, running;
    logic        busy, runOk, runErr;
    err_code_t   lastErrCode;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          hi;

    // ****************************************
    // clock, design ends and checker
    // ****************************************
    always #5 core_clk = ~core_clk;
    run_limit_if link();
    run_limit_dev run_limit_dev_inst (.cmd(link), .core_clk(core_clk), .rst_b(rst_b),
        .myNumber(8'hff), .remoteLinked(remoteLinked), .limitCfg(limitCfg),
        .limitPin(limitPin), .pulseOut(pulseOut), .dirOut(dirOut), .running(running));
    run_limit_host run_limit_host_inst (.cmd(link), .core_clk(core_clk), .rst_b(rst_b),
        .startRun(startRun), .startReadErr(startReadErr), .userModule(8'hff),
        .userOut(userOut), .userFreq(userFreq), .userLimit(userLimit), .userDuty(userDuty),
        .userDir(userDir), .userDisable(userDisable), .busy(busy), .runOk(runOk),
        .runErr(runErr), .lastErrCode(lastErrCode));
    run_limit_checker run_limit_checker_inst (.core_clk(core_clk), .rst_b(rst_b),
        .cmdReq(link.cmdReq), .cmdCode(link.cmdCode), .freqHz(link.freqHz),
        .limitSel(link.limitSel), .dutyCode(link.dutyCode), .doneOk(link.doneOk),
        .doneErr(link.doneErr), .errCode(link.errCode), .errCodeValid(link.errCodeValid));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one host operation, then wait for the host to fall idle
    task automatic do_start(input logic rd, input logic [1:0] ch, input logic [7:0] lim,
                            input logic [15:0] f, input logic [7:0] duty);
        userOut = ch;
        userLimit = lim;
        userFreq = f;
        userDuty = duty;
        startRun = !rd;
        startReadErr = rd;
        @(negedge core_clk);
        startRun = 1'b0;
        startReadErr = 1'b0;
        repeat (2) @(negedge core_clk);
        repeat (400)
            if (busy === 1'b1)
                @(negedge core_clk);
        `CHK("idle", 1'b0, busy)
    endtask

    // high cycles of one output over a window
    task automatic count_high(input int ch, input int n);
        hi = 0;
        repeat (n)
        begin
            @(negedge core_clk);
            hi += int'(pulseOut[ch] === 1'b1);
        end
    endtask

    task automatic err_case(input logic [3:0] cfg, input logic [7:0] lim,
                            input logic [15:0] f, input logic [7:0] duty, input err_code_t code);
        limitCfg = cfg;
        do_start(1'b0, 2'h0, lim, f, duty);
        `CHK("runErr", code != `ERR_NONE, runErr)
        `CHK("runOk", code == `ERR_NONE, runOk)
        do_start(1'b1, 2'h0, lim, f, duty);
        `CHK("lastErrCode", code, lastErrCode)
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_run_rise();
        do_start(1'b0, 2'h2, 8'h02, 16'd20000, 8'h00);
        `CHK("runOk", 1'b1, runOk)
        `CHK("running2", 1'b1, running[2])
        `CHK("dir2", 1'b1, dirOut[2])
        count_high(2, 10000);
        `CHK("high50", 5000, hi)
        limitPin[2] = 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK("running2", 1'b0, running[2])
        `CHK("pulse2", 1'b0, pulseOut[2])
    endtask

    task automatic s_run_fall();
        userDir = 1'b0;
        do_start(1'b0, 2'h1, 8'h11, 16'd20000, 8'h25);
        `CHK("dir1", 1'b0, dirOut[1])
        `CHK("dir2", 1'b1, dirOut[2])
        count_high(1, 10000);
        `CHK("high25", 2500, hi)
        limitPin[1] = 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK("running1", 1'b1, running[1])
        limitPin[1] = 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK("running1", 1'b0, running[1])
    endtask

    task automatic s_errors();
        err_case(4'h7, 8'h03, 16'd20000, 8'h00, `ERR_NOT_LIMIT);
        err_case(4'hf, 8'h04, 16'd20000, 8'h00, `ERR_NOT_LIMIT);
        err_case(4'hf, 8'h30, 16'd20000, 8'h00, `ERR_EDGE_RANGE);
        err_case(4'hf, 8'h00, 16'd19, 8'h00, `ERR_BAD_CMD);
        err_case(4'hf, 8'h00, 16'd20001, 8'h00, `ERR_BAD_CMD);
        err_case(4'hf, 8'h00, 16'd20000, 8'h9a, `ERR_BAD_CMD);
        err_case(4'hf, 8'h00, 16'd20000, 8'ha0, `ERR_BAD_CMD);
        err_case(4'h1, 8'h00, 16'd20000, 8'h50, `ERR_NONE);
    endtask

    task automatic s_remote();
        remoteLinked = 1'b1;
        err_case(4'h0, 8'h00, 16'd20000, 8'h00, `ERR_REMOTE);
        remoteLinked = 1'b0;
        do_start(1'b1, 2'h0, 8'h00, 16'd20000, 8'h00);
        `CHK("keptCode", `ERR_NOT_LIMIT, lastErrCode)
    endtask

    task automatic s_run_both();
        limitCfg = 4'hf;
        limitPin[3] = 1'b1;
        repeat (8) @(negedge core_clk);
        do_start(1'b0, 2'h3, 8'h23, 16'd20, 8'h99);
        `CHK("runOk", 1'b1, runOk)
        `CHK("running3", 1'b1, running[3])
        limitPin[3] = 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK("running3", 1'b0, running[3])
        userDisable = 4'h1;
        repeat (4) @(negedge core_clk);
        count_high(0, 5000);
        `CHK("high0", 0, hi)
    endtask

    // main sequence after five reset cycles
    initial
    begin
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        s_run_rise();
        s_run_fall();
        s_errors();
        s_remote();
        s_run_both();
        test_done();
    end

    // watchdog sized well above the expected run
    initial
    begin
        #500000;
        n_mismatch++;
        test_done();
    end
endmodule
